// [rtl/four_port_gpio_pullup.sv]
// Four 8-bit GPIO ports with latch, direction and pin sample registers,
// plus a chip control register holding the global pull-up disable.
// Assumes an AXI4-Lite master on clock and pads that merge out/oe/pullup.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cfg.svh"

// How it works
// (RULE1) Global pull-up disable set forces every pull-up off.
// (RULE2) Pull-up on only for direction 0, latch 1, disable 0.
// (RULE3) Each port has an 8-bit read/write output latch, reset to zero.
// (RULE4) Each port has an 8-bit read/write direction register, reset zero.
// (RULE5) Each port has a pin level register returning synchronised pins.
// (RULE6) Control bit 4 is pull-up disable, resets zero; bits 3:2 read zero.
// (RULE7) Direction bit one enables the pin's output driver.
// (RULE8) Output pins carry latch bits; pins are sampled on the clock.
module four_port_gpio_pullup (
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [7:0]        awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [7:0]        araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	input  wire gpio_pkg::port_set_t pin_in,
	output gpio_pkg::port_set_t    pin_out,
	output gpio_pkg::port_set_t    pin_oe,
	output gpio_pkg::port_set_t    pullup_en
);

	localparam gpio_pkg::reg_idx_t PIN_IDX [4] = '{`PORT_A_PIN_IDX,
		`PORT_B_PIN_IDX, `PORT_C_PIN_IDX, `PORT_D_PIN_IDX};
	localparam gpio_pkg::reg_idx_t DIR_IDX [4] = '{`PORT_A_DIR_IDX,
		`PORT_B_DIR_IDX, `PORT_C_DIR_IDX, `PORT_D_DIR_IDX};
	localparam gpio_pkg::reg_idx_t LATCH_IDX [4] = '{`PORT_A_LATCH_IDX,
		`PORT_B_LATCH_IDX, `PORT_C_LATCH_IDX, `PORT_D_LATCH_IDX};

	logic                 awready_r;
	logic                 wready_r;
	logic                 bvalid_r;
	logic [1:0]           bresp_r;
	logic                 arready_r;
	logic                 rvalid_r;
	logic [31:0]          rdata_r;
	logic [1:0]           rresp_r;
	logic [7:0]           awaddr_r;
	logic [31:0]          wdata_r;
	logic                 wstrb0_r;
	logic                 wr_fire;
	gpio_pkg::reg_idx_t   wr_idx;
	gpio_pkg::reg_idx_t   rd_idx;
	logic                 wr_known;
	logic                 rd_known;
	logic [31:0]          rd_mux;
	logic                 pud_r;
	gpio_pkg::port_set_t  dir_r;
	gpio_pkg::port_set_t  latch_r;
	gpio_pkg::port_set_t  pin_meta_r;
	gpio_pkg::port_set_t  pin_sync_r;
	gpio_pkg::port_set_t  pullup_r;
	gpio_pkg::port_set_t  pullup_calc;

	assign awready   = awready_r;
	assign wready    = wready_r;
	assign bvalid    = bvalid_r;
	assign bresp     = bresp_r;
	assign arready   = arready_r;
	assign rvalid    = rvalid_r;
	assign rdata     = rdata_r;
	assign rresp     = rresp_r;
	// (RULE8) Latch drives pins
	assign pin_out   = latch_r;
	// (RULE7) Direction enables drivers
	assign pin_oe    = dir_r;
	assign pullup_en = pullup_r;

	assign wr_idx  = awaddr_r[7:2];
	assign rd_idx  = araddr[7:2];
	// Address and data are both held and no response is pending.
	// It is high for one clock per write, so each write lands only once.
	assign wr_fire = !awready_r && !wready_r && !bvalid_r;

	// Unmapped indices are answered with an error and change nothing.
	function automatic logic idx_known(input gpio_pkg::reg_idx_t idx);
		idx_known = (idx <= `PORT_D_LATCH_IDX) || (idx == `CHIP_CONTROL_IDX);
	endfunction : idx_known

	assign wr_known = idx_known(wr_idx);
	assign rd_known = idx_known(rd_idx);

	// Write address and data are taken independently, in either order.
	always_ff @(posedge clock) begin
		if (reset) begin
			awready_r <= 1'b1;
			awaddr_r  <= 8'h00;
		end else if (awvalid && awready_r) begin
			awready_r <= 1'b0;
			awaddr_r  <= awaddr;
		end else if (bvalid_r && bready) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wready_r <= 1'b1;
			wdata_r  <= 32'h00000000;
			wstrb0_r <= 1'b0;
		end else if (wvalid && wready_r) begin
			wready_r <= 1'b0;
			wdata_r  <= wdata;
			wstrb0_r <= wstrb[0];
		end else if (bvalid_r && bready) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid_r && bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Pull-up disable lives in byte lane 0 only.
	// (RULE6) Disable bit write
	always_ff @(posedge clock) begin
		if (reset) begin
			pud_r <= `PUD_RESET;
		end else if (wr_fire && wstrb0_r && wr_idx == `CHIP_CONTROL_IDX) begin
			pud_r <= wdata_r[`PUD_BIT];
		end
	end

	// Read mux: narrow registers sit in the low byte, upper bits read zero.
	always_comb begin
		rd_mux = 32'h00000000;
		for (int p = 0; p < 4; p++) begin
			// (RULE5) Pin levels read back
			if (rd_idx == PIN_IDX[p]) begin
				rd_mux[7:0] = pin_sync_r[p];
			end
			if (rd_idx == DIR_IDX[p]) begin
				rd_mux[7:0] = dir_r[p];
			end
			if (rd_idx == LATCH_IDX[p]) begin
				rd_mux[7:0] = latch_r[p];
			end
		end
		// (RULE6) Reserved bits zero
		if (rd_idx == `CHIP_CONTROL_IDX) begin
			rd_mux[`PUD_BIT] = pud_r;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `RESP_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rd_mux;
			rresp_r   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	generate
		for (genvar p = 0; p < 4; p++) begin : g_port
			// (RULE3) Latch write path
			always_ff @(posedge clock) begin
				if (reset) begin
					latch_r[p] <= `LATCH_RESET;
				end else if (wr_fire && wstrb0_r && wr_idx == LATCH_IDX[p]) begin
					latch_r[p] <= wdata_r[7:0];
				end
			end

			// (RULE4) Direction write path
			always_ff @(posedge clock) begin
				if (reset) begin
					dir_r[p] <= `DIR_RESET;
				end else if (wr_fire && wstrb0_r && wr_idx == DIR_IDX[p]) begin
					dir_r[p] <= wdata_r[7:0];
				end
			end

			// Pads are asynchronous: only the second stage feeds logic.
			// (RULE8) Two-stage pin sampling
			always_ff @(posedge clock) begin
				if (reset) begin
					pin_meta_r[p] <= 8'h00;
					pin_sync_r[p] <= 8'h00;
				end else begin
					pin_meta_r[p] <= pin_in[p];
					pin_sync_r[p] <= pin_meta_r[p];
				end
			end

			// (RULE2) Pull-up pair select
			assign pullup_calc[p] = ~dir_r[p] & latch_r[p] & {8{~pud_r}};

			// Registered so the pad control leaves a flip-flop; it lags a
			// register write by one clock, which the pads tolerate.
			// (RULE1) Global disable gating
			always_ff @(posedge clock) begin
				if (reset) begin
					pullup_r[p] <= 8'h00;
				end else begin
					pullup_r[p] <= pullup_calc[p];
				end
			end

			sequence latch_write_s;
				wr_fire && wstrb0_r && wr_idx == LATCH_IDX[p];
			endsequence

			sequence dir_write_s;
				wr_fire && wstrb0_r && wr_idx == DIR_IDX[p];
			endsequence

			AST_LATCH_WRITE: assert property (@(posedge clock) disable iff (reset) // RULE3
				latch_write_s |=> pin_out[p] == $past(wdata_r[7:0]))
				else $error("Latch write did not reach the pin output.");

			AST_DIR_WRITE: assert property (@(posedge clock) disable iff (reset) // RULE4
				dir_write_s |=> dir_r[p] == $past(wdata_r[7:0]))
				else $error("Direction write was not stored.");

			AST_OE_FOLLOWS: assert property (@(posedge clock) disable iff (reset) // RULE7
				dir_write_s |=> pin_oe[p] == $past(wdata_r[7:0]) ##1
				$stable(pin_oe[p]))
				else $error("Output enable does not follow the direction.");

			AST_PIN_SAMPLE: assert property (@(posedge clock) disable iff (reset) // RULE8
				!$past(reset, 2) |-> pin_sync_r[p] == $past(pin_in[p], 2))
				else $error("Pin level sample is not two clocks behind the pin.");

			// (RULE5) Pin level writes ignored
			AST_PIN_WRITE_NOP: assert property (@(posedge clock) disable iff (reset) // RULE5
				wr_fire && wr_idx == PIN_IDX[p]
				|=> $stable(latch_r) && $stable(dir_r))
				else $error("A pin level write changed a port register.");
		end
	endgenerate

	sequence ctrl_read_s;
		arvalid && arready_r && rd_idx == `CHIP_CONTROL_IDX;
	endsequence

	sequence write_pending_s;
		!awready_r && !wready_r && !bvalid_r;
	endsequence

	AST_PUD_OFF: assert property (@(posedge clock) disable iff (reset) // RULE1
		pud_r |=> pullup_en == '0)
		else $error("A pull-up is on while the global disable is set.");

	AST_PULLUP_PAIR: assert property (@(posedge clock) disable iff (reset) // RULE2
		1'b1 |=> pullup_en == $past(~dir_r & latch_r & {32{~pud_r}}))
		else $error("Pull-up does not match direction, latch and disable.");

	AST_RESET_CLEAR: assert property (@(posedge clock) disable iff (reset) // RULE4
		$fell(reset) |-> dir_r == '0 && latch_r == '0 && !pud_r && !bvalid_r)
		else $error("Registers not cleared after reset.");

	AST_PIN_READ: assert property (@(posedge clock) disable iff (reset) // RULE5
		arvalid && arready_r && rd_idx == `PORT_A_PIN_IDX
		|=> rvalid && rdata == {24'h000000, $past(pin_sync_r[0])})
		else $error("Pin level read returned the wrong value.");

	AST_CTRL_READ: assert property (@(posedge clock) disable iff (reset) // RULE6
		ctrl_read_s |=> rvalid && rdata[3:2] == 2'h0
		&& rdata[`PUD_BIT] == $past(pud_r) && rresp == `RESP_OKAY)
		else $error("Control read shows wrong disable or reserved bits.");

	// The response rises one clock after address and data are both held,
	// whatever bready does; a master may keep bready high all the time.
	AST_WRITE_RESP: assert property (@(posedge clock) disable iff (reset)
		write_pending_s |=> bvalid)
		else $error("Write response did not follow address and data.");

	sequence write_unmapped_s;
		!awready_r && !wready_r && !bvalid_r && !wr_known;
	endsequence

	sequence read_unmapped_s;
		arvalid && arready_r && !rd_known;
	endsequence

	sequence write_done_s;
		bvalid && bready;
	endsequence

	sequence read_done_s;
		rvalid && rready;
	endsequence

	AST_WRITE_SLVERR: assert property (@(posedge clock) disable iff (reset)
		write_unmapped_s |=> bvalid && bresp == `RESP_SLVERR)
		else $error("Unmapped write was not answered with an error.");

	AST_READ_SLVERR: assert property (@(posedge clock) disable iff (reset)
		read_unmapped_s |=> rvalid && rdata == 32'h00000000
		&& rresp == `RESP_SLVERR)
		else $error("Unmapped read was not answered with zero and an error.");

	// Each channel stays closed from its take until its answer is accepted,
	// so a second request can never overwrite a held one.
	AST_AW_CLOSED: assert property (@(posedge clock) disable iff (reset)
		awvalid && awready |=> !awready)
		else $error("Write address channel stayed open after a take.");

	AST_WRITE_REOPEN: assert property (@(posedge clock) disable iff (reset)
		write_done_s |=> !bvalid && awready && wready)
		else $error("Write channels did not reopen after the response.");

	AST_READ_REOPEN: assert property (@(posedge clock) disable iff (reset)
		read_done_s |=> !rvalid && arready)
		else $error("Read channel did not reopen after the data.");

endmodule : four_port_gpio_pullup
`default_nettype wire

// [include/gpio_cfg.svh]
// Register indices, field positions, reset values and bus answers of the
// four-port GPIO block. Byte address of a register is four times its index.
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

`define PORT_A_PIN_IDX    6'h00
`define PORT_A_DIR_IDX    6'h01
`define PORT_A_LATCH_IDX  6'h02
`define PORT_B_PIN_IDX    6'h03
`define PORT_B_DIR_IDX    6'h04
`define PORT_B_LATCH_IDX  6'h05
`define PORT_C_PIN_IDX    6'h06
`define PORT_C_DIR_IDX    6'h07
`define PORT_C_LATCH_IDX  6'h08
`define PORT_D_PIN_IDX    6'h09
`define PORT_D_DIR_IDX    6'h0A
`define PORT_D_LATCH_IDX  6'h0B
`define CHIP_CONTROL_IDX  6'h35

`define PUD_BIT           4
`define DIR_RESET         8'h00
`define LATCH_RESET       8'h00
`define PUD_RESET         1'b0

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [include/gpio_pkg.sv]
// Types shared by the four-port GPIO block.
// Assumes gpio_cfg.svh is compiled alongside for the numeric constants.
`default_nettype none
package gpio_pkg;
	typedef logic [7:0]      port_byte_t;
	typedef logic [3:0][7:0] port_set_t;
	typedef logic [5:0]      reg_idx_t;
endpackage : gpio_pkg
`default_nettype wire

// [tb/pad_board.sv]
// Board-side model of the 32 pads: block driver, pull-up, external driver.
// Assumes the bench enables at most one external driver per pad.
`timescale 1ns/1ps
`default_nettype none
module pad_board (
	input  wire logic                clock,
	input  wire gpio_pkg::port_set_t pin_out,
	input  wire gpio_pkg::port_set_t pin_oe,
	input  wire gpio_pkg::port_set_t pullup_en,
	input  wire gpio_pkg::port_set_t ext_en,
	input  wire gpio_pkg::port_set_t ext_val,
	output gpio_pkg::port_set_t      pin_level
);
	// A floating pad toggles so a stale level can never pass for a read.
	logic float_r = 1'b0;
	always_ff @(posedge clock) begin
		float_r <= ~float_r;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 8; j++) begin
				if (pin_oe[i][j])
					pin_level[i][j] = pin_out[i][j];
				else if (ext_en[i][j])
					pin_level[i][j] = ext_val[i][j];
				else if (pullup_en[i][j])
					pin_level[i][j] = 1'b1;
				else
					pin_level[i][j] = float_r;
			end
		end
	end
endmodule : pad_board
`default_nettype wire

// [tb/testbench.sv]
// Register and pad tests of the four-port GPIO block over AXI4-Lite.
// Assumes the pad model resolves every pin fed back to pin_in.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cfg.svh"
module testbench;
	logic clock = 1'b0;
	logic reset = 1'b1;
	// Both answer readies stay high: the bench never stalls a response.
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
	logic arvalid = 1'b0, rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] d;
	logic [7:0] dv, lv;
	gpio_pkg::port_set_t pin_in, pin_out, pin_oe, pu, ext_en, ext_val;
	int error_cnt = 0, n_compared = 0, cyc = 0;
	always #4 clock = ~clock;
	four_port_gpio_pullup i_dut (.clock(clock), .reset(reset),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_en(pu));
	pad_board i_pads (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_en(pu), .ext_en(ext_en), .ext_val(ext_val),
		.pin_level(pin_in));
	task results();
		if (error_cnt == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v,
		output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!aw_done || !w_done) begin
			@(posedge clock);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock); while (bvalid !== 1'b1);
		r = bresp;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
	endtask : rd
	// Register byte address of port p, kind k (0 pins, 1 dir, 2 latch).
	function automatic logic [7:0] ra(input int p, input int k);
		return 8'(4 * (3 * p + k));
	endfunction : ra
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			results();
		end
	end
	initial begin
		ext_en = '0;
		ext_val = '0;
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			rd(ra(p, 1), d, rs);
			chk(d, 32'h0);
			rd(ra(p, 2), d, rs);
			chk(d, 32'h0);
		end
		rd(8'hD4, d, rs);
		chk(d, 32'h0);
		for (int p = 0; p < 4; p++) begin
			dv = 8'hF0 ^ 8'(p);
			lv = 8'h5A ^ 8'(p << 4);
			ext_en[p] <= ~dv;
			ext_val[p] <= 8'hC3;
			wr(ra(p, 1), dv, rs);
			wr(ra(p, 2), lv, rs);
			rd(ra(p, 1), d, rs);
			chk(d, {24'h0, dv});
			rd(ra(p, 2), d, rs);
			chk(d, {24'h0, lv});
			@(posedge clock);
			chk(pin_oe[p], dv);
			chk(pin_out[p], lv);
			chk(pu[p], ~dv & lv);
			rd(ra(p, 0), d, rs);
			chk(d, {24'h0, (dv & lv) | (~dv & 8'hC3)});
			wr(ra(p, 0), 8'hFF, rs);
			chk(rs, `RESP_OKAY);
		end
		wr(8'hD4, 8'hFF, rs);
		rd(8'hD4, d, rs);
		chk(d, 32'h10);
		chk(rs, `RESP_OKAY);
		@(posedge clock);
		chk(pu, '0);
		wr(8'hD4, 8'h00, rs);
		@(posedge clock);
		chk(pu[0], 8'h0A);
		wstrb <= 4'hE;
		wr(ra(0, 2), 8'hFF, rs);
		wstrb <= 4'hF;
		rd(ra(0, 2), d, rs);
		chk(d, 32'h5A);
		wr(8'h30, 8'h11, rs);
		chk(rs, `RESP_SLVERR);
		rd(8'h30, d, rs);
		chk(d, 32'h0);
		chk(rs, `RESP_SLVERR);
		results();
	end
endmodule : testbench
`default_nettype wire
